// ==== shared/uec_pkg.sv ====
// uec_pkg: register map, field positions, reset values, timing counts,
// bus carrier and event structs for the uart error and control slice.
// assumes a single 125 MHz core clock shared by every user of the package.
package uec_pkg;
	localparam logic [15:0] UEC_CTRL0_ADDR = 16'h0098;
	localparam logic [15:0] UEC_BUF0_ADDR = 16'h0099;
	localparam logic [15:0] UEC_STAT0_ADDR = 16'h00BA;
	localparam logic [15:0] UEC_STAT1_ADDR = 16'h00D4;
	localparam logic [15:0] UEC_GEN1_ADDR = 16'hFFB3;
	localparam logic [15:0] UEC_DIVLO_ADDR = 16'hFFB4;
	localparam logic [15:0] UEC_DIVHI_ADDR = 16'hFFB5;
	localparam logic [15:0] UEC_AUX_ADDR = 16'hFFC0;
	// serial0_control fields
	localparam int UEC_C_RXDONE = 0;
	localparam int UEC_C_TXDONE = 1;
	localparam int UEC_C_RX9 = 2;
	localparam int UEC_C_TX9 = 3;
	localparam int UEC_C_REN = 4;
	localparam int UEC_C_MODE_UP = 7;
	// baud_gen1_control fields
	localparam int UEC_G_EN = 0;
	localparam int UEC_G_SEL = 1;
	// status fields
	localparam int UEC_S_FE = 0;
	localparam int UEC_S_BRK = 1;
	// aux control fields
	localparam int UEC_A_EVS = 0;
	localparam int UEC_A_BRR = 1;
	localparam int UEC_A_REN1 = 2;
	localparam int UEC_A_MODE1 = 3;
	localparam logic [7:0] UEC_CTRL0_RST = 8'h00;
	localparam logic [1:0] UEC_GEN1_RST = 2'h0;
	localparam logic [4:0] UEC_AUX_RST = 5'h00;
	localparam logic [15:0] UEC_DIV_RST = 16'h0000;
	// timing: 16 samples per bit, break after 11 low bit samples
	localparam logic [3:0] UEC_OS_LAST = 4'hF;
	localparam logic [3:0] UEC_OS_MID = 4'h8;
	localparam logic [3:0] UEC_BRK_LAST = 4'hA;
	localparam logic [15:0] UEC_DIV_RELOAD = 16'h000F;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uec_bus_s;
	typedef struct packed {
		logic done;
		logic [7:0] data;
		logic ninth;
		logic ferr;
		logic brk;
	} uec_rx_ev_s;
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_HUNT, RX_BRK, RX_SHIFT0
	} uec_rxst_e;
endpackage : uec_pkg

// ==== core/uec_core.sv ====
// uec_core: uart0 control flags, transmitter and receiver, uart1 receiver
// for error and break detection, second rate generator, register port.
// assumes a same-clock register master and asynchronous serial pins.
// Overview of operation
// - generator enable bit; divisor locked while enabled
// - select bit picks generator for uart1 modes 1,3
// - low stop bit sets framing error status
// - error view selects frame error in bit 7
// - eleven low bit samples flag a break
// - every break also flags a framing error
// - after break wait for a high bit
// - uart0 break resets device into programming mode
// - uart1 break never resets, raises interrupt only
// - receive done: mode0 bit 8, mode1 mid-stop
// - modes 2,3 done timing by error view
// - transmit done at bit 8 or stop bit
// - ninth bit captures bit 9 or stop bit
// - transmit ninth bit sent in modes 2,3
// - receive enable gates reception
// - frame: low start, eight data lsb first, high stop
// - start bit begins reception only when enabled
// - any data buffer write starts a transmission
`timescale 1ns/10ps
`default_nettype none

module uec_rx
	import uec_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic os_tick_i,
	input wire logic rxd_i,
	input wire logic en_i,
	input wire logic [1:0] mode_i,
	input wire logic evs_i,
	input wire logic rxdone_i,
	output uec_rx_ev_s ev_o
);
	typedef struct packed {
		uec_rxst_e st;
		logic [3:0] os;
		logic [3:0] bitn;
		logic [3:0] bcnt;
		logic [8:0] sh;
		uec_rx_ev_s ev;
	} uec_rx_s;
	uec_rx_s r;
	uec_rx_s n;
	logic samp;
	logic brk_hit;
	logic [8:0] nsh;

	always_comb begin
		n = r;
		n.ev.done = 1'b0;
		n.ev.ferr = 1'b0;
		n.ev.brk = 1'b0;
		samp = os_tick_i && (r.os == UEC_OS_LAST);
		brk_hit = samp && !rxd_i && (r.bcnt == UEC_BRK_LAST);
		nsh = {rxd_i, r.sh[8:1]};
		if (os_tick_i)
			n.os = r.os + 4'h1;
		// count only bit-centre samples from start bit through stop bit and hunt
		if (samp && r.st != RX_IDLE && r.st != RX_BRK && r.st != RX_SHIFT0)
			n.bcnt = rxd_i ? 4'h0 : r.bcnt + 4'h1;
		case (r.st)
			RX_IDLE: begin
				n.bcnt = 4'h0;
				if (mode_i == 2'h0) begin
					if (!rxdone_i) begin
						n.st = RX_SHIFT0;
						n.os = 4'h0;
						n.bitn = 4'h0;
					end
				end else if (os_tick_i && !rxd_i) begin
					n.st = RX_START;
					n.os = UEC_OS_MID;
				end
			end
			RX_START: if (samp) begin
				n.st = rxd_i ? RX_IDLE : RX_BITS;
				n.bitn = 4'h0;
			end
			RX_BITS: if (samp) begin
				n.sh = nsh;
				n.bitn = r.bitn + 4'h1;
				if (r.bitn == (mode_i[1] ? 4'h8 : 4'h7)) begin
					n.st = RX_STOP;
					n.ev.data = mode_i[1] ? nsh[7:0] : nsh[8:1];
					if (mode_i[1]) begin
						n.ev.ninth = nsh[8];
						n.ev.done = !evs_i;
					end
				end
			end
			RX_STOP: if (samp) begin
				if (!mode_i[1] || evs_i)
					n.ev.done = 1'b1;
				if (!mode_i[1])
					n.ev.ninth = rxd_i;
				n.ev.ferr = !rxd_i;
				n.ev.brk = brk_hit;
				n.st = rxd_i ? RX_IDLE : (brk_hit ? RX_BRK : RX_HUNT);
			end
			RX_HUNT: if (samp) begin
				if (rxd_i)
					n.st = RX_IDLE;
				else if (brk_hit) begin
					n.ev.brk = 1'b1;
					n.ev.ferr = 1'b1;
					n.st = RX_BRK;
				end
			end
			RX_BRK: if (samp && rxd_i)
				n.st = RX_IDLE;
			RX_SHIFT0: if (samp) begin
				n.sh = nsh;
				n.bitn = r.bitn + 4'h1;
				if (r.bitn == 4'h7) begin
					n.ev.data = nsh[8:1];
					n.ev.done = 1'b1;
					n.st = RX_IDLE;
				end
			end
			default: n.st = RX_IDLE;
		endcase
		if (!en_i) begin
			n.st = RX_IDLE;
			n.ev.done = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '{st: RX_IDLE, default: '0};
		end else begin
			r <= n;
		end
	end

	assign ev_o = r.ev;

	default clocking cb_rx @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	chk_break_count: assert property (ev_o.brk |-> $past(r.bcnt) == 4'hA)
		else $error("break flagged without eleven low samples");
	chk_break_ferr: assert property (ev_o.brk |-> ev_o.ferr)
		else $error("break without framing error");
	chk_break_idle: assert property (ev_o.brk && $past(en_i) |-> r.st == RX_BRK)
		else $error("receiver not parked after break");
	chk_rx_gate: assert property (!en_i |=> !ev_o.done)
		else $error("reception while disabled");
endmodule : uec_rx

module uec_core
	import uec_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire uec_bus_s bus_i,
	output logic [7:0] rdata_o,
	input wire logic timer1_ovf_i,
	input wire logic uart0_rxd_i,
	input wire logic uart1_rxd_i,
	output logic uart0_txd_o,
	output logic dev_reset_o,
	output logic isp_request_o,
	output logic uart1_break_irq_o
);
	typedef struct packed {
		logic s0a;
		logic s0b;
		logic s1a;
		logic s1b;
		logic [7:0] ctrl0;
		logic fe0;
		logic brk0;
		logic fe1;
		logic brk1;
		logic [1:0] gen1;
		logic [15:0] div;
		logic [15:0] gcnt;
		logic [4:0] aux;
		logic m2;
		logic [7:0] rxbuf;
		logic [7:0] rdata;
		logic [10:0] txsh;
		logic [3:0] txn;
		logic [3:0] txos;
		logic txd;
		logic rstp;
	} uec_core_s;
	uec_core_s r;
	uec_core_s n;
	uec_rx_ev_s ev0;
	uec_rx_ev_s ev1;
	logic [1:0] mode0;
	logic [1:0] mode1;
	logic evs;
	logic gen_tick;
	logic os0;
	logic os1;
	logic wr_ctrl;
	logic wr_buf;
	logic tx_edge;
	logic [10:0] tx_next;

	assign evs = r.aux[UEC_A_EVS];
	assign mode0 = r.ctrl0[7:6];
	assign mode1 = r.aux[UEC_A_MODE1+1:UEC_A_MODE1];
	assign gen_tick = r.gen1[UEC_G_EN] && (r.gcnt == 16'h0000);
	assign wr_ctrl = bus_i.wr && (bus_i.addr == UEC_CTRL0_ADDR);
	assign wr_buf = bus_i.wr && (bus_i.addr == UEC_BUF0_ADDR);

	// mode 2 fixed at clk/32; uart0 variable modes use the timer overflow
	always_comb begin
		case (mode0)
			2'h0: os0 = 1'b1;
			2'h2: os0 = r.m2;
			default: os0 = timer1_ovf_i;
		endcase
		case (mode1)
			2'h0: os1 = 1'b1;
			2'h2: os1 = r.m2;
			default: os1 = r.gen1[UEC_G_SEL] ? gen_tick : timer1_ovf_i;
		endcase
	end

	uec_rx u_rx0 (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.os_tick_i(os0),
		.rxd_i(r.s0b),
		.en_i(r.ctrl0[UEC_C_REN]),
		.mode_i(mode0),
		.evs_i(evs),
		.rxdone_i(r.ctrl0[UEC_C_RXDONE]),
		.ev_o(ev0)
	);

	// uart1 control register lives elsewhere; its mode 0 start is never held off
	uec_rx u_rx1 (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.os_tick_i(os1),
		.rxd_i(r.s1b),
		.en_i(r.aux[UEC_A_REN1]),
		.mode_i(mode1),
		.evs_i(evs),
		.rxdone_i(1'b0),
		.ev_o(ev1)
	);

	always_comb begin
		n = r;
		n.s0a = uart0_rxd_i;
		n.s0b = r.s0a;
		n.s1a = uart1_rxd_i;
		n.s1b = r.s1a;
		n.m2 = ~r.m2;
		n.rstp = 1'b0;
		tx_edge = os0 && (r.txn != 4'h0) && (r.txos == UEC_OS_LAST);
		tx_next = {1'b1, r.txsh[10:1]};
		// rate generator, period divisor plus sixteen clocks
		if (!r.gen1[UEC_G_EN])
			n.gcnt = 16'h0000;
		else if (gen_tick)
			n.gcnt = 16'(r.div + UEC_DIV_RELOAD);
		else
			n.gcnt = r.gcnt - 16'h0001;
		// register writes
		if (bus_i.wr) begin
			case (bus_i.addr)
				UEC_CTRL0_ADDR: begin
					n.ctrl0[6:0] = bus_i.wdata[6:0];
					if (evs)
						n.fe0 = bus_i.wdata[UEC_C_MODE_UP];
					else
						n.ctrl0[UEC_C_MODE_UP] = bus_i.wdata[UEC_C_MODE_UP];
				end
				UEC_STAT0_ADDR: begin
					n.fe0 = r.fe0 & ~bus_i.wdata[UEC_S_FE];
					n.brk0 = r.brk0 & ~bus_i.wdata[UEC_S_BRK];
				end
				UEC_STAT1_ADDR: begin
					n.fe1 = r.fe1 & ~bus_i.wdata[UEC_S_FE];
					n.brk1 = r.brk1 & ~bus_i.wdata[UEC_S_BRK];
				end
				UEC_GEN1_ADDR: n.gen1 = bus_i.wdata[1:0];
				// an interim divisor would glitch a running generator
				UEC_DIVLO_ADDR: if (!r.gen1[UEC_G_EN])
					n.div[7:0] = bus_i.wdata;
				UEC_DIVHI_ADDR: if (!r.gen1[UEC_G_EN])
					n.div[15:8] = bus_i.wdata;
				UEC_AUX_ADDR: n.aux = bus_i.wdata[4:0];
				default: n.aux = r.aux;
			endcase
		end
		// transmitter
		if (wr_buf) begin
			n.txsh = {1'b1, mode0[1] ? r.ctrl0[UEC_C_TX9] : 1'b1, bus_i.wdata, 1'b0};
			if (mode0 == 2'h0) begin
				n.txsh = {3'b111, bus_i.wdata};
				n.txn = 4'h8;
			end else begin
				n.txn = mode0[1] ? 4'hB : 4'hA;
			end
			n.txd = n.txsh[0];
			n.txos = 4'h0;
		end else if (tx_edge) begin
			n.txsh = tx_next;
			n.txd = tx_next[0];
			n.txn = r.txn - 4'h1;
			if (r.txn == ((mode0 == 2'h0) ? 4'h1 : 4'h2))
				n.ctrl0[UEC_C_TXDONE] = 1'b1;
		end
		if (os0 && !wr_buf)
			n.txos = r.txos + 4'h1;
		// receive events; hardware sets win over software clears
		if (ev0.done) begin
			n.ctrl0[UEC_C_RXDONE] = 1'b1;
			n.rxbuf = ev0.data;
			if (mode0 != 2'h0)
				n.ctrl0[UEC_C_RX9] = ev0.ninth;
		end
		if (ev0.ferr)
			n.fe0 = 1'b1;
		if (ev0.brk) begin
			n.brk0 = 1'b1;
			n.rstp = r.aux[UEC_A_BRR];
		end
		if (ev1.ferr)
			n.fe1 = 1'b1;
		if (ev1.brk)
			n.brk1 = 1'b1;
		// reads answer one cycle later; unmapped reads as zero
		n.rdata = 8'h00;
		if (bus_i.rd) begin
			case (bus_i.addr)
				UEC_CTRL0_ADDR: n.rdata = {evs ? r.fe0 : r.ctrl0[7], r.ctrl0[6:0]};
				UEC_BUF0_ADDR: n.rdata = r.rxbuf;
				UEC_STAT0_ADDR: n.rdata = {6'h00, r.brk0, r.fe0};
				UEC_STAT1_ADDR: n.rdata = {6'h00, r.brk1, r.fe1};
				UEC_GEN1_ADDR: n.rdata = {6'h00, r.gen1};
				UEC_DIVLO_ADDR: n.rdata = r.div[7:0];
				UEC_DIVHI_ADDR: n.rdata = r.div[15:8];
				UEC_AUX_ADDR: n.rdata = {3'h0, r.aux};
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
			r.s0a <= 1'b1;
			r.s0b <= 1'b1;
			r.s1a <= 1'b1;
			r.s1b <= 1'b1;
			r.txd <= 1'b1;
			r.ctrl0 <= UEC_CTRL0_RST;
			r.gen1 <= UEC_GEN1_RST;
			r.aux <= UEC_AUX_RST;
			r.div <= UEC_DIV_RST;
		end else begin
			r <= n;
		end
	end

	assign rdata_o = r.rdata;
	assign uart0_txd_o = r.txd;
	assign dev_reset_o = r.rstp;
	assign isp_request_o = r.rstp;
	assign uart1_break_irq_o = r.brk1;

	default clocking cb_core @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	chk_div_lock: assert property (
		bus_i.wr && bus_i.addr == UEC_DIVLO_ADDR && r.gen1[UEC_G_EN]
		|=> r.div == $past(r.div))
		else $error("divisor changed while generator enabled");
	chk_gen_idle: assert property (
		!r.gen1[UEC_G_EN] && !(bus_i.wr && bus_i.addr == UEC_GEN1_ADDR)
		|=> !gen_tick)
		else $error("generator ticks while disabled");
	chk_src_select: assert property (
		mode1 == 2'h1 && r.gen1[UEC_G_SEL] |-> os1 == gen_tick)
		else $error("uart1 rate source wrong");
	chk_ctrl_view: assert property (
		bus_i.rd && bus_i.addr == UEC_CTRL0_ADDR && evs
		|=> rdata_o[7] == $past(r.fe0))
		else $error("control bit 7 not showing frame error");
	chk_fe_break: assert property (
		ev0.brk |=> r.fe0 && r.brk0)
		else $error("break did not flag framing error");
	chk_break_reset: assert property (
		ev0.brk && r.aux[UEC_A_BRR] |=> dev_reset_o && isp_request_o)
		else $error("uart0 break did not reset device");
	chk_u1_noreset: assert property (
		ev1.brk && !ev0.brk |=> !dev_reset_o ##0 uart1_break_irq_o)
		else $error("uart1 break misrouted");
	chk_rx_sticky: assert property (
		r.ctrl0[UEC_C_RXDONE] && !wr_ctrl |=> r.ctrl0[UEC_C_RXDONE])
		else $error("receive done cleared by hardware");
	chk_tx_start: assert property (
		wr_buf |=> r.txn != 4'h0 ##0 !uart0_txd_o || mode0 == 2'h0)
		else $error("buffer write did not start transmit");
	cov_break0: cover property (ev0.brk && r.aux[UEC_A_BRR]);
	cov_rx_done: cover property (ev0.done ##1 r.ctrl0[UEC_C_RXDONE]);
	cov_tx_done: cover property ($rose(r.ctrl0[UEC_C_TXDONE]));
	cov_u1_break: cover property ($rose(uart1_break_irq_o));
endmodule : uec_core

`default_nettype wire

// ==== tb/uec_remote.sv ====
// uec_remote: far-end serial peer; sends frames to both uarts, hears uart0.
// assumes a bit time of BIT core clocks; lines idle high as if pulled up.
`timescale 1ns/10ps
`default_nettype none
module uec_remote #(
	parameter int BIT = 32
) (
	input wire logic core_clk_i,
	input wire logic txd_i,
	output logic rxd0_o,
	output logic rxd1_o,
	output logic [7:0] got_o,
	output logic got_v_o
);
	initial begin
		rxd0_o = 1'b1;
		rxd1_o = 1'b1;
		got_o = 8'h00;
		got_v_o = 1'b0;
	end
	// bits leave lsb first; an all-zero frame is how a break is sent
	task automatic send(input logic u, input logic [12:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_i);
			if (u) begin
				rxd1_o <= f[i];
			end else begin
				rxd0_o <= f[i];
			end
			repeat (BIT - 1) @(posedge core_clk_i);
		end
		@(posedge core_clk_i);
		rxd0_o <= 1'b1;
		rxd1_o <= 1'b1;
	endtask : send
	// mid-bit sampling; a byte whose stop bit is low is not reported
	always begin
		@(negedge txd_i);
		repeat (BIT / 2) @(posedge core_clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge core_clk_i);
			got_o[i] = txd_i;
		end
		repeat (BIT) @(posedge core_clk_i);
		got_v_o = txd_i;
		@(posedge core_clk_i);
		got_v_o = 1'b0;
	end
endmodule : uec_remote
`default_nettype wire

// ==== tb/test_uart_error_and_control.sv ====
// test_uart_error_and_control: self-checking bench for uec_core.
// assumes timer overflow every second clock, so one bit is 32 clocks.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_uart_error_and_control
	import uec_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic timer1_ovf_i = 1'b0;
	uec_bus_s bus = '0;
	logic [7:0] rdata_o, got, d, e8;
	logic rxd0, rxd1, txd, dev_rst, isp, brk1, got_v, n9;
	logic rd_pend = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] tx_q[$];
	int miscompares = 0;
	int cmp_count = 0;
	int resets = 0;
	always #4 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) timer1_ovf_i <= ~timer1_ovf_i;
	uec_core DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus),
		.rdata_o(rdata_o), .timer1_ovf_i(timer1_ovf_i), .uart0_rxd_i(rxd0),
		.uart1_rxd_i(rxd1), .uart0_txd_o(txd), .dev_reset_o(dev_rst),
		.isp_request_o(isp), .uart1_break_irq_o(brk1));
	uec_remote #(.BIT(32)) rem (.core_clk_i(core_clk_i), .txd_i(txd),
		.rxd0_o(rxd0), .rxd1_o(rxd1), .got_o(got), .got_v_o(got_v));
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= v;
		@(posedge core_clk_i);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge core_clk_i);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge core_clk_i);
		bus.rd <= 1'b0;
	endtask : rd
	// read data stand only in the cycle after the strobe
	always @(negedge core_clk_i) begin
		if (rd_pend) begin
			e8 = exp_q.pop_front();
			`CHK("rdata", e8, rdata_o)
		end
		rd_pend = bus.rd;
		if (dev_rst === 1'b1) begin
			resets++;
		end
		`CHK("isp", dev_rst, isp)
		if (got_v === 1'b1) begin
			e8 = tx_q.pop_front();
			`CHK("txbyte", e8, got)
		end
	end
	task automatic test_done();
		$display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic frame0(input logic [12:0] f, input int n);
		rem.send(1'b0, f, n);
		// idle gap so a receiver parked in hunt or break sees a high bit
		repeat (48) @(posedge core_clk_i);
	endtask : frame0
	initial begin
		repeat (20000) @(posedge core_clk_i);
		miscompares++;
		test_done();
	end
	initial begin
		void'($urandom(69611));
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(UEC_CTRL0_ADDR, 8'h00);
		rd(UEC_GEN1_ADDR, 8'h00);
		rd(16'h1234, 8'h00);
		wr(UEC_DIVLO_ADDR, 8'hA5);
		rd(UEC_DIVLO_ADDR, 8'hA5);
		wr(UEC_GEN1_ADDR, 8'h01);
		wr(UEC_DIVLO_ADDR, 8'h3C);
		wr(UEC_DIVHI_ADDR, 8'h3C);
		rd(UEC_DIVLO_ADDR, 8'hA5);
		rd(UEC_DIVHI_ADDR, 8'h00);
		wr(UEC_GEN1_ADDR, 8'h02);
		rd(UEC_GEN1_ADDR, 8'h02);
		wr(UEC_GEN1_ADDR, 8'h00);
		$display("test registers done");
		wr(UEC_CTRL0_ADDR, 8'h50);
		d = 8'($urandom());
		frame0({4'hF, d, 1'b0}, 10);
		rd(UEC_CTRL0_ADDR, 8'h55);
		rd(UEC_BUF0_ADDR, d);
		rd(UEC_STAT0_ADDR, 8'h00);
		wr(UEC_CTRL0_ADDR, 8'h40);
		frame0({4'hF, ~d, 1'b0}, 10);
		rd(UEC_CTRL0_ADDR, 8'h40);
		rd(UEC_BUF0_ADDR, d);
		$display("test mode1 receive done");
		wr(UEC_CTRL0_ADDR, 8'h50);
		wr(UEC_AUX_ADDR, 8'h01);
		frame0({4'h0, d, 1'b0}, 10);
		rd(UEC_CTRL0_ADDR, 8'hD1);
		rd(UEC_STAT0_ADDR, 8'h01);
		wr(UEC_CTRL0_ADDR, 8'h50);
		rd(UEC_STAT0_ADDR, 8'h00);
		wr(UEC_AUX_ADDR, 8'h00);
		$display("test framing error done");
		for (int m = 2; m < 4; m++) begin
			wr(UEC_CTRL0_ADDR, {2'(m), 6'h10});
			d = 8'($urandom());
			n9 = 1'($urandom());
			frame0({3'h7, n9, d, 1'b0}, 11);
			rd(UEC_CTRL0_ADDR, {2'(m), 3'h2, n9, 2'h1});
			rd(UEC_BUF0_ADDR, d);
		end
		$display("test ninth bit done");
		wr(UEC_CTRL0_ADDR, 8'h50);
		wr(UEC_AUX_ADDR, 8'h02);
		frame0(13'h0000, 13);
		rd(UEC_STAT0_ADDR, 8'h03);
		`CHK("resets", 1, resets)
		wr(UEC_STAT0_ADDR, 8'h03);
		wr(UEC_CTRL0_ADDR, 8'h50);
		d = 8'($urandom());
		frame0({4'hF, d, 1'b0}, 10);
		rd(UEC_BUF0_ADDR, d);
		rd(UEC_STAT0_ADDR, 8'h00);
		$display("test uart0 break done");
		wr(UEC_AUX_ADDR, 8'h0C);
		rem.send(1'b1, 13'h0000, 13);
		repeat (48) @(posedge core_clk_i);
		`CHK("brk1", 1'b1, brk1)
		`CHK("resets", 1, resets)
		rd(UEC_STAT1_ADDR, 8'h03);
		wr(UEC_STAT1_ADDR, 8'h03);
		rd(UEC_STAT1_ADDR, 8'h00);
		// generator picked but far slower than the frame: nothing detected
		wr(UEC_GEN1_ADDR, 8'h03);
		rem.send(1'b1, 13'h0000, 13);
		repeat (48) @(posedge core_clk_i);
		rd(UEC_STAT1_ADDR, 8'h00);
		wr(UEC_GEN1_ADDR, 8'h00);
		$display("test uart1 break done");
		wr(UEC_CTRL0_ADDR, 8'h50);
		d = 8'($urandom());
		tx_q.push_back(d);
		wr(UEC_BUF0_ADDR, d);
		repeat (340) @(posedge core_clk_i);
		rd(UEC_CTRL0_ADDR, 8'h52);
		`CHK("txleft", 0, tx_q.size())
		$display("test transmit done");
		// mode 0 shifts in the idle-high line: eight ones, then holds off
		wr(UEC_CTRL0_ADDR, 8'h10);
		repeat (140) @(posedge core_clk_i);
		rd(UEC_CTRL0_ADDR, 8'h11);
		rd(UEC_BUF0_ADDR, 8'hFF);
		$display("test mode0 receive done");
		repeat (4) @(posedge core_clk_i);
		test_done();
	end
endmodule : test_uart_error_and_control
`default_nettype wire
